// ===== test_timer2_shift_in_irq_logic.sv
// Bench for the timer 2, shift-in and interrupt block.
// Assumes via_irq and via_peer are compiled alongside.
`timescale 1ns/1ns
module test_timer2_shift_in_irq_logic;
  logic        mclk, srst, cs, rd_wr, port_a_access, t1_out, pulse_n;
  logic        clk_pin, ext_clk, sdata, sclk_out, sclk_oe_n;
  logic        irq_out, irq_oe_n, tt_pin, tt_oe_n, rd_taken;
  logic [3:0]  reg_sel;
  logic [6:0]  flag_set, ier_m;
  logic [7:0]  wdata, rdata, b;
  logic [15:0] e;
  logic [15:0] q[$];
  int          n_mismatch, total_checks, seed, cyc, n;

  assign clk_pin = sclk_oe_n ? ext_clk : sclk_out;

  via_irq u_via_irq (.mclk(mclk), .srst(srst), .cs(cs), .reg_sel(reg_sel),
    .rd_wr(rd_wr), .wdata(wdata), .rdata(rdata),
    .port_a_access(port_a_access), .flag_set_ext(flag_set),
    .t1_out(t1_out), .pulse_count_pin(pulse_n), .shift_clk_in(clk_pin),
    .shift_data_in(sdata), .shift_clk_out(sclk_out),
    .shift_clk_oe_n(sclk_oe_n), .irq_out(irq_out), .irq_oe_n(irq_oe_n),
    .timer_toggle_pin(tt_pin), .timer_toggle_oe_n(tt_oe_n));

  via_peer u_via_peer (.mclk(mclk), .clk_pin(clk_pin), .dev_clk(~sclk_oe_n),
    .ext_clk(ext_clk), .sdata(sdata), .pulse_n(pulse_n));

  // Clock, 50 ns period
  initial begin
    mclk = 1'b0;
    forever #25 mclk = ~mclk;
  end

  task close_out;
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : close_out

  task check(input logic [7:0] seen, input logic [7:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED t=%0t seen %h exp %h", $time, seen, exp);
    end
  endtask : check

  // Expected flag read: bit 7 is any enabled flag
  function automatic logic [7:0] f(input logic [6:0] fl);
    return {|(fl & ier_m), fl};
  endfunction : f

  task acc(input logic [3:0] s, input logic r, input logic [7:0] d);
    @(posedge mclk);
    #2 cs = 1'b1;
    reg_sel = s;
    rd_wr = r;
    wdata = d;
    @(posedge mclk);
    #2 cs = 1'b0;
  endtask : acc

  task wr(input logic [3:0] s, input logic [7:0] d);
    if (s == 4'hE)
      ier_m = d[7] ? (ier_m | d[6:0]) : (ier_m & ~d[6:0]);
    acc(s, 1'b0, d);
  endtask : wr

  task rd(input logic [3:0] s, input logic [7:0] x, input logic [7:0] m);
    q.push_back({m, x & m});
    acc(s, 1'b1, 8'h00);
  endtask : rd

  task pulse_in(input logic [6:0] fs, input logic pa);
    @(posedge mclk);
    #2 flag_set = fs;
    port_a_access = pa;
    @(posedge mclk);
    #2 flag_set = 7'h00;
    port_a_access = 1'b0;
  endtask : pulse_in

  // Read results compared in the half cycle after the taking edge
  always @(posedge mclk) rd_taken <= cs & rd_wr & ~srst;
  always @(negedge mclk) begin
    if (rd_taken) begin
      e = q.pop_front();
      check(rdata & e[15:8], e[7:0]);
    end
  end

  // Hang guard
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 70000) begin
      n_mismatch++;
      close_out();
    end
  end

  initial begin
    {cs, rd_wr, port_a_access, t1_out, reg_sel, flag_set, wdata} = '0;
    {n_mismatch, total_checks, cyc, ier_m} = '0;
    seed = 42;
    srst = 1'b1;
    repeat (12) @(posedge mclk);
    #2 srst = 1'b0;
    rd(4'hD, 8'h00, 8'hFF);
    rd(4'hE, 8'h80, 8'hFF);
    check(irq_oe_n, 1'b1);
    repeat (4) begin
      b = $random(seed);
      wr(4'hE, b);
      rd(4'hE, {1'b1, ier_m}, 8'hFF);
    end
    wr(4'hE, 8'hFF);
    wr(4'hE, 8'h5F);
    rd(4'hE, 8'hA0, 8'hFF);
    $display("test enables done");
    wr(4'h8, 8'h02);
    wr(4'h9, 8'h00);
    n = 0;
    while (irq_oe_n !== 1'b0 && n < 20) begin
      @(posedge mclk);
      #1 n++;
    end
    check(n, 4);
    rd(4'h9, 8'hFF, 8'hFF);
    rd(4'hD, f(7'h20), 8'hFF);
    rd(4'h8, 8'h00, 8'h00);
    rd(4'hD, 8'h00, 8'hFF);
    repeat (65545) @(posedge mclk);
    rd(4'hD, 8'h00, 8'hFF);
    wr(4'hB, 8'h20);
    wr(4'h8, 8'h02);
    wr(4'h9, 8'h00);
    u_via_peer.pulses(2);
    rd(4'hD, 8'h00, 8'hFF);
    u_via_peer.pulses(1);
    rd(4'hD, f(7'h20), 8'hFF);
    wr(4'h9, 8'h00);
    rd(4'hD, 8'h00, 8'hFF);
    $display("test timer done");
    pulse_in(7'h5B, 1'b0);
    wr(4'hE, 8'hC0);
    rd(4'hD, f(7'h5B), 8'hFF);
    wr(4'hD, 8'hC0);
    rd(4'hD, f(7'h1B), 8'hFF);
    check(irq_oe_n, 1'b1);
    wr(4'hC, 8'h22);
    wr(4'h0, 8'h00);
    pulse_in(7'h00, 1'b1);
    rd(4'hD, f(7'h09), 8'hFF);
    wr(4'hD, 8'h7F);
    rd(4'hD, 8'h00, 8'hFF);
    $display("test flags done");
    wr(4'h2, 8'h80);
    wr(4'hB, 8'h80);
    repeat (4) begin
      #2 t1_out = $random(seed);
      repeat (2) @(posedge mclk);
      check(tt_pin, t1_out);
    end
    wr(4'hB, 8'h00);
    wr(4'h0, 8'h80);
    repeat (2) @(posedge mclk);
    check(tt_pin, 1'b1);
    check(tt_oe_n, 1'b0);
    $display("test toggle pin done");
    // Timer 2 fired once interval mode resumed; clear it
    wr(4'hD, 8'h20);
    wr(4'hA, 8'h5A);
    rd(4'hA, 8'h5A, 8'hFF);
    rd(4'hD, 8'h00, 8'hFF);
    wr(4'hE, 8'h84);
    for (int i = 0; i < 2; i++) begin
      wr(4'hB, i ? 8'h04 : 8'h08);
      b = $random(seed);
      u_via_peer.load(b);
      rd(4'hA, 8'h00, 8'h00);
      repeat (64) @(posedge mclk);
      check(sclk_out, 1'b1);
      check(sclk_oe_n, 1'b0);
      check(irq_oe_n, 1'b0);
      rd(4'hD, f(7'h04), 8'hFF);
      rd(4'hA, b, 8'hFF);
      repeat (64) @(posedge mclk);
    end
    wr(4'hB, 8'h0C);
    rd(4'hA, 8'h00, 8'h00);
    for (int i = 0; i < 2; i++) begin
      b = $random(seed);
      u_via_peer.frame(b);
      repeat (3) @(posedge mclk);
      rd(4'hD, f(7'h04), 8'hFF);
      rd(4'hA, b, 8'hFF);
      rd(4'hD, 8'h00, 8'hFF);
    end
    $display("test shifter done");
    repeat (4) @(posedge mclk);
    close_out();
  end
endmodule : test_timer2_shift_in_irq_logic

// ===== via_irq.sv
// Timer 2, shift-in register and interrupt flag/enable logic.
// Assumes a one-cycle access strobe synchronous to mclk and open-drain
// pins resolved outside from the output enables.
`timescale 1ns/1ns
`include "via_irq_defs.svh"
module via_irq (
  input  wire logic                  mclk,
  input  wire logic                  srst,
  input  wire logic                  cs,
  input  wire logic [3:0]            reg_sel,
  input  wire logic                  rd_wr,
  input  wire logic [7:0]            wdata,
  output      logic [7:0]            rdata,
  input  wire logic                  port_a_access,
  input  wire logic [6:0]            flag_set_ext,
  input  wire logic                  t1_out,
  input  wire logic                  pulse_count_pin,
  input  wire logic                  shift_clk_in,
  input  wire logic                  shift_data_in,
  output      logic                  shift_clk_out,
  output      logic                  shift_clk_oe_n,
  output      logic                  irq_out,
  output      logic                  irq_oe_n,
  output      logic                  timer_toggle_pin,
  output      logic                  timer_toggle_oe_n
);
  import via_irq_pkg::*;

  via_irq_pkg::state_t st_reg;
  via_irq_pkg::state_t st_next;

  logic       wr;
  logic       rd;
  logic [2:0] mode;
  logic [6:0] clr;
  logic [6:0] set;
  logic       t2_step;
  logic       t2_hit;
  logic       sh_acc;
  logic       irq_any;

  // Access decode and mode
  assign wr = cs & ~rd_wr;
  assign rd = cs & rd_wr;
  assign mode = st_reg.aux_control[`ACR_SH_HI:`ACR_SH_LO];
  assign sh_acc = cs && (reg_sel == `OFS_SHIFTER);
  assign irq_any = |(st_reg.interrupt_flag_reg & st_reg.interrupt_enable_reg);

  // Timer 2 step source: every cycle or falling pulse pin
  assign t2_step = st_reg.aux_control[`ACR_T2_PULSE] ?
                   (st_reg.pb6_prev & ~pulse_count_pin) : 1'b1;
  assign t2_hit = t2_step && (st_reg.t2_cnt == `CNT_ZERO) && st_reg.t2_armed;

  // Next-state logic
  always_comb begin
    st_next = st_reg;
    clr = 7'h00;
    set = flag_set_ext;
    set[`FLG_T2] = 1'b0;
    set[`FLG_SR] = 1'b0;
    st_next.pb6_prev = pulse_count_pin;
    st_next.cb1_prev = shift_clk_in;

    // Plain register writes
    if (wr && reg_sel == `OFS_PORT_B_OUT) begin
      st_next.port_b_output = wdata;
    end else if (wr && reg_sel == `OFS_PORT_B_DIR) begin
      st_next.port_b_direction = wdata;
    end else if (wr && reg_sel == `OFS_T2_LOW) begin
      st_next.t2_latch = wdata;
    end else if (wr && reg_sel == `OFS_AUX_CTRL) begin
      st_next.aux_control = wdata;
    end else if (wr && reg_sel == `OFS_PERIPH_CTRL) begin
      st_next.peripheral_control = wdata;
    end else if (wr && reg_sel == `OFS_IFR) begin
      clr = wdata[6:0];
    end else if (wr && reg_sel == `OFS_IER) begin
      if (wdata[`SET_CLR_BIT]) begin
        st_next.interrupt_enable_reg = st_reg.interrupt_enable_reg | wdata[6:0];
      end else begin
        st_next.interrupt_enable_reg = st_reg.interrupt_enable_reg & ~wdata[6:0];
      end
    end

    // Port B access clears CB1, and CB2 unless independent
    if (cs && reg_sel == `OFS_PORT_B_OUT) begin
      clr[`FLG_CB1] = 1'b1;
      if (st_reg.peripheral_control[7:5] != `PCR_IND_NEG &&
          st_reg.peripheral_control[7:5] != `PCR_IND_POS) begin
        clr[`FLG_CB2] = 1'b1;
      end
    end
    if (port_a_access) begin
      clr[`FLG_CA1] = 1'b1;
      if (st_reg.peripheral_control[3:1] != `PCR_IND_NEG &&
          st_reg.peripheral_control[3:1] != `PCR_IND_POS) begin
        clr[`FLG_CA2] = 1'b1;
      end
    end

    // Timer 2 counter
    if (t2_step) begin
      st_next.t2_cnt = st_reg.t2_cnt - 16'h0001;
    end
    if (t2_hit) begin
      set[`FLG_T2] = 1'b1;
      st_next.t2_armed = 1'b0;
    end
    if (wr && reg_sel == `OFS_T2_HIGH) begin
      st_next.t2_cnt = {wdata, st_reg.t2_latch};
      st_next.t2_armed = 1'b1;
      clr[`FLG_T2] = 1'b1;
    end
    if (rd && reg_sel == `OFS_T2_LOW) begin
      clr[`FLG_T2] = 1'b1;
    end

    // Shifter: capture stage shifts one cycle after a rising clock
    if (st_reg.sh_cap) begin
      st_next.sh_cap = 1'b0;
      st_next.sr = {st_reg.sr[6:0], shift_data_in};
      st_next.sh_cnt = st_reg.sh_cnt + 3'h1;
      if (st_reg.sh_cnt == `SH_LAST) begin
        set[`FLG_SR] = 1'b1;
        if (mode != `SH_BY_EXT) begin
          st_next.sh_state = SH_IDLE;
        end
      end
    end
    case (st_reg.sh_state)
      SH_IDLE: begin
        st_next.sh_clk = 1'b1;
      end
      SH_RUN: begin
        if (mode == `SH_BY_EXT) begin
          if (~st_reg.cb1_prev & shift_clk_in) begin
            st_next.sh_cap = 1'b1;
          end
        end else if (mode == `SH_BY_T2 || mode == `SH_BY_CLK) begin
          if (mode == `SH_BY_CLK || st_reg.sh_div == `BYTE_ZERO) begin
            st_next.sh_div = st_reg.t2_latch;
            st_next.sh_clk = ~st_reg.sh_clk;
            st_next.sh_cap = ~st_reg.sh_clk;
          end else begin
            st_next.sh_div = st_reg.sh_div - 8'h01;
          end
        end else begin
          st_next.sh_state = SH_IDLE;
        end
      end
      default: begin
        st_next.sh_state = SH_IDLE;
      end
    endcase
    // Eighth device-clocked bit: park the clock high, no stray capture
    if (st_reg.sh_cap && st_reg.sh_cnt == `SH_LAST &&
        mode != `SH_BY_EXT) begin
      st_next.sh_clk = 1'b1;
      st_next.sh_cap = 1'b0;
      st_next.sh_state = SH_IDLE;
    end
    if (sh_acc) begin
      if (wr) begin
        st_next.sr = wdata;
      end
      clr[`FLG_SR] = 1'b1;
      st_next.sh_cnt = 3'h0;
      st_next.sh_cap = 1'b0;
      st_next.sh_clk = 1'b1;
      st_next.sh_div = st_reg.t2_latch;
      if (mode != `SH_OFF) begin
        st_next.sh_state = SH_RUN;
      end
    end

    // Flags: set wins over clear
    st_next.interrupt_flag_reg = (st_reg.interrupt_flag_reg & ~clr) | set;
    if (mode == `SH_OFF) begin
      st_next.interrupt_flag_reg[`FLG_SR] = 1'b0;
    end

    // Read data
    st_next.rdata = st_reg.rdata;
    if (rd) begin
      if (reg_sel == `OFS_PORT_B_OUT) begin
        st_next.rdata = st_reg.port_b_output;
      end else if (reg_sel == `OFS_PORT_B_DIR) begin
        st_next.rdata = st_reg.port_b_direction;
      end else if (reg_sel == `OFS_T2_LOW) begin
        st_next.rdata = st_reg.t2_cnt[7:0];
      end else if (reg_sel == `OFS_T2_HIGH) begin
        st_next.rdata = st_reg.t2_cnt[15:8];
      end else if (reg_sel == `OFS_SHIFTER) begin
        st_next.rdata = st_reg.sr;
      end else if (reg_sel == `OFS_AUX_CTRL) begin
        st_next.rdata = st_reg.aux_control;
      end else if (reg_sel == `OFS_PERIPH_CTRL) begin
        st_next.rdata = st_reg.peripheral_control;
      end else if (reg_sel == `OFS_IFR) begin
        st_next.rdata = {irq_any, st_reg.interrupt_flag_reg};
      end else if (reg_sel == `OFS_IER) begin
        st_next.rdata = {1'b1, st_reg.interrupt_enable_reg};
      end else begin
        st_next.rdata = `BYTE_ZERO;
      end
    end

    // Pins
    st_next.irq_oe_n = ~irq_any;
    if (st_reg.port_b_direction[`PIN_BIT] && st_reg.aux_control[`ACR_T1_PIN]) begin
      st_next.tpin = t1_out;
    end else begin
      st_next.tpin = st_reg.port_b_output[`PIN_BIT];
    end
    st_next.tpin_oe_n = ~st_reg.port_b_direction[`PIN_BIT];
    st_next.sclk_oe_n = ~(mode == `SH_BY_T2 || mode == `SH_BY_CLK);
  end

  // State register
  always_ff @(posedge mclk) begin
    if (srst) begin
      st_reg <= '0;
      st_reg.irq_oe_n <= 1'b1;
      st_reg.tpin_oe_n <= 1'b1;
      st_reg.sclk_oe_n <= 1'b1;
      st_reg.sh_clk <= 1'b1;
      st_reg.pb6_prev <= 1'b1;
      st_reg.cb1_prev <= 1'b1;
    end else begin
      st_reg <= st_next;
    end
  end

  // Outputs straight from state, irq_out tied low
  assign rdata = st_reg.rdata;
  assign shift_clk_out = st_reg.sh_clk;
  assign shift_clk_oe_n = st_reg.sclk_oe_n;
  assign irq_out = 1'b0;
  assign irq_oe_n = st_reg.irq_oe_n;
  assign timer_toggle_pin = st_reg.tpin;
  assign timer_toggle_oe_n = st_reg.tpin_oe_n;

  // Checks
  default clocking cb @(posedge mclk); endclocking
  default disable iff (srst);

  a_ier_set: assert property (wr && reg_sel == `OFS_IER && wdata[7]
    |=> (st_reg.interrupt_enable_reg & $past(wdata[6:0])) == $past(wdata[6:0]))
    else $error("enable bits not set");
  a_ier_clr: assert property (wr && reg_sel == `OFS_IER && !wdata[7]
    |=> (st_reg.interrupt_enable_reg & $past(wdata[6:0])) == 7'h00)
    else $error("enable bits not cleared");
  a_ier_read: assert property (rd && reg_sel == `OFS_IER
    |=> rdata == {1'b1, $past(st_reg.interrupt_enable_reg)})
    else $error("enable read wrong");
  a_irq_drive: assert property (irq_any |=> !irq_oe_n ##0 !irq_out)
    else $error("request not driven");
  a_ifr_wc: assert property (wr && reg_sel == `OFS_IFR && wdata[3]
    && !flag_set_ext[3] |=> !st_reg.interrupt_flag_reg[3])
    else $error("flag not cleared");
  a_sr_off: assert property ($past(mode) == `SH_OFF
    |-> !st_reg.interrupt_flag_reg[`FLG_SR])
    else $error("shifter flag set while off");
  a_t2_load: assert property (wr && reg_sel == `OFS_T2_HIGH
    |=> st_reg.t2_armed && !st_reg.interrupt_flag_reg[`FLG_T2]
        && st_reg.t2_cnt[15:8] == $past(wdata))
    else $error("timer 2 load wrong");
  a_t2_once: assert property ($rose(st_reg.interrupt_flag_reg[`FLG_T2])
    |-> !st_reg.t2_armed)
    else $error("timer 2 still armed");
  a_t1_pin: assert property (st_reg.port_b_direction[7] && st_reg.aux_control[7]
    |=> timer_toggle_pin == $past(t1_out))
    else $error("toggle pin not timer output");

  // Timer 2 counting, roll-over and flag clear on low-byte read
  a_t2_step: assert property (!st_reg.aux_control[`ACR_T2_PULSE]
    && !(wr && reg_sel == `OFS_T2_HIGH)
    |=> st_reg.t2_cnt == $past(st_reg.t2_cnt) - 16'h0001)
    else $error("timer 2 did not step");
  a_t2_roll: assert property (t2_hit
    && !(wr && reg_sel == `OFS_T2_HIGH)
    |=> st_reg.t2_cnt == ~`CNT_ZERO)
    else $error("timer 2 did not roll over");
  a_t2_rdclr: assert property (rd && reg_sel == `OFS_T2_LOW
    && !t2_hit |=> !st_reg.interrupt_flag_reg[`FLG_T2])
    else $error("timer 2 flag not cleared by read");

  // Flag register read-back
  a_ifr_read: assert property (rd && reg_sel == `OFS_IFR
    |=> rdata == {$past(irq_any), $past(st_reg.interrupt_flag_reg)})
    else $error("flag read wrong");

  // Shifter sequencing
  a_sr_shift: assert property (st_reg.sh_cap && !sh_acc
    |=> st_reg.sr == {$past(st_reg.sr[6:0]), $past(shift_data_in)})
    else $error("shifter did not take the data bit");
  a_sr_stop: assert property (st_reg.sh_cap && !sh_acc
    && st_reg.sh_cnt == `SH_LAST && mode != `SH_BY_EXT
    |=> st_reg.sh_state == SH_IDLE && shift_clk_out)
    else $error("shifter clock did not stop high");
  a_sr_acc: assert property (sh_acc && !st_reg.sh_cap
    |=> st_reg.sh_cnt == 3'h0 && !st_reg.interrupt_flag_reg[`FLG_SR])
    else $error("shifter access did not restart");
  a_sr_ext: assert property (mode == `SH_BY_EXT && !sh_acc
    && st_reg.sh_state == SH_RUN |=> st_reg.sh_state == SH_RUN)
    else $error("external shifting halted");
  a_sclk_drv: assert property (mode == `SH_BY_T2 || mode == `SH_BY_CLK
    |=> !shift_clk_oe_n)
    else $error("shift clock not driven");

  // Main scenarios reached
  c_ext_frame: cover property (mode == `SH_BY_EXT && st_reg.sh_cap);
  c_pulse_hit: cover property (st_reg.aux_control[`ACR_T2_PULSE] && t2_hit);
  c_t2_fire: cover property ($rose(st_reg.interrupt_flag_reg[`FLG_T2]));
  c_sr_done: cover property ($rose(st_reg.interrupt_flag_reg[`FLG_SR]));
  c_irq_low: cover property ($fell(irq_oe_n));
endmodule : via_irq

// ===== via_irq_defs.svh
// Offsets, fields and constants for the timer 2 / shift-in / irq block.
// Assumes inclusion by bare name from the design file.
`ifndef VIA_IRQ_DEFS_SVH
`define VIA_IRQ_DEFS_SVH
// Register select codes
`define OFS_PORT_B_OUT  4'h0
`define OFS_PORT_B_DIR  4'h2
`define OFS_T2_LOW      4'h8
`define OFS_T2_HIGH     4'h9
`define OFS_SHIFTER     4'hA
`define OFS_AUX_CTRL    4'hB
`define OFS_PERIPH_CTRL 4'hC
`define OFS_IFR         4'hD
`define OFS_IER         4'hE
// Aux control fields
`define ACR_T1_PIN      7
`define ACR_T2_PULSE    5
`define ACR_SH_HI       4
`define ACR_SH_LO       2
// Shift modes
`define SH_OFF          3'h0
`define SH_BY_T2        3'h1
`define SH_BY_CLK       3'h2
`define SH_BY_EXT       3'h3
// Flag bit positions
`define FLG_T2          5
`define FLG_SR          2
`define FLG_CB1         4
`define FLG_CB2         3
`define FLG_CA1         1
`define FLG_CA2         0
// Peripheral control: independent interrupt codes
`define PCR_IND_NEG     3'h1
`define PCR_IND_POS     3'h3
// Misc
`define SET_CLR_BIT     7
`define PIN_BIT         7
`define BYTE_ZERO       8'h00
`define CNT_ZERO        16'h0000
`define SH_LAST         3'h7
`endif

// ===== via_irq_pkg.sv
// Types for the timer 2 / shift-in / interrupt block.
// Assumes via_irq_defs.svh is visible on the include path.
package via_irq_pkg;
  // Shifter sequencer, Gray coded
  typedef enum logic [1:0] {
    SH_IDLE = 2'b00,
    SH_RUN  = 2'b01
  } sh_state_t;

  // Whole block state
  typedef struct packed {
    logic [7:0]  port_b_output;
    logic [7:0]  port_b_direction;
    logic [7:0]  aux_control;
    logic [7:0]  peripheral_control;
    logic [7:0]  t2_latch;
    logic [15:0] t2_cnt;
    logic        t2_armed;
    logic        pb6_prev;
    logic [7:0]  sr;
    sh_state_t   sh_state;
    logic [2:0]  sh_cnt;
    logic [7:0]  sh_div;
    logic        sh_clk;
    logic        sh_cap;
    logic        cb1_prev;
    logic [6:0]  interrupt_flag_reg;
    logic [6:0]  interrupt_enable_reg;
    logic [7:0]  rdata;
    logic        irq_oe_n;
    logic        tpin;
    logic        tpin_oe_n;
    logic        sclk_oe_n;
  } state_t;
endpackage : via_irq_pkg

// ===== via_peer.sv
// Far-side model: serial peer on the shift pins and the pulse source.
// Assumes the bench resolves the shift clock pin and calls its tasks.
`timescale 1ns/1ns
module via_peer (
  input  wire logic mclk,
  input  wire logic clk_pin,
  input  wire logic dev_clk,
  output logic      ext_clk,
  output logic      sdata,
  output logic      pulse_n
);
  logic [7:0] tx;

  // Idle levels: clock parked high, no pulse
  initial begin
    ext_clk = 1'b1;
    sdata   = 1'b0;
    pulse_n = 1'b1;
    tx      = 8'h00;
  end

  // Next bit after each device-driven fall; stale bits scrambled
  always @(negedge clk_pin) begin
    if (dev_clk) begin
      sdata = tx[7];
      tx    = {tx[6:0], ~tx[7]};
    end
  end

  // Queue a byte for a device-clocked transfer
  task load(input logic [7:0] v);
    tx    = v;
    sdata = ~sdata;
  endtask : load

  // Externally clocked byte, data held three cycles past the rise
  task frame(input logic [7:0] v);
    for (int i = 7; i >= 0; i--) begin
      @(posedge mclk);
      #5 sdata = v[i];
      ext_clk = 1'b0;
      repeat (2) @(posedge mclk);
      #5 ext_clk = 1'b1;
      repeat (3) @(posedge mclk);
    end
    #5 sdata = ~sdata;
  endtask : frame

  // Negative pulses, each low across two sampling edges
  task pulses(input int n);
    repeat (n) begin
      @(posedge mclk);
      #5 pulse_n = 1'b0;
      repeat (2) @(posedge mclk);
      #5 pulse_n = 1'b1;
      repeat (2) @(posedge mclk);
    end
  endtask : pulses
endmodule : via_peer
